// ### hw/adc_channel_select_result.v
// channel select and result holding logic of a successive approximation converter
// assumes an apb master on clk, and a sar core that reports each finished conversion
// with a one-cycle done pulse, its 12-bit value and an in-range flag from the limit
// compare logic
`timescale 1ns/10ps
`include "adc_chsel_regs.vh"

module adc_channel_select_result (
  input wire clk, // 100 MHz peripheral clock
  input wire resetn, // asynchronous reset, active low
  input wire psel, // apb select
  input wire penable, // apb access phase
  input wire pwrite, // apb direction
  input wire [11:0] paddr, // apb byte address
  input wire [31:0] pwdata, // apb write data
  output reg [31:0] prdata, // apb read data
  output reg pready, // apb ready
  output reg pslverr, // apb error on unmapped address
  input wire conv_done, // one-cycle pulse: conversion finished
  input wire [11:0] sar_value, // successive approximation value
  input wire in_range, // limit compare accepts this value
  output reg [5:0] mux_channel, // code driven to the analog multiplexer
  output reg mux_internal, // internal source selected
  output reg [1:0] scan_slot, // current scan slot
  output reg setting_prohibited // current select setting is not allowed
);

  // register state
  reg [7:0] chsel_r;
  reg [6:0] ctrl_r;
  reg [15:0] result_r;
  reg [7:0] result_byte_r;
  reg [1:0] slot_r;
  reg access_r;

  wire internal_source_select = chsel_r[`CHSEL_ISS_BIT];
  wire [5:0] code = chsel_r[5:0];
  wire channel_selection_mode = ctrl_r[`CTRL_MODE_BIT];
  wire [1:0] scan_count_select = ctrl_r[`CTRL_CNT_HI:`CTRL_CNT_LO];
  wire channel_tag_enable = ctrl_r[`CTRL_TAG_BIT];
  wire single_conv = ctrl_r[`CTRL_SINGLE_BIT];
  wire conversion_start_bit = ctrl_r[`CTRL_START_BIT];
  wire comparator_enable_bit = ctrl_r[`CTRL_CMPEN_BIT];

  // last slot index and legality of the start code for each scan width
  reg [1:0] last_slot;
  reg prohibited_nxt;
  always @* begin
    last_slot = 2'd0;
    prohibited_nxt = 1'b0;
    if (!channel_selection_mode) begin
      if (internal_source_select) begin
        prohibited_nxt = (code != `CODE_TEMP) && (code != `CODE_BGR);
      end else begin
        prohibited_nxt = (code > `MAX_SEL_EXT) && (code != `CODE_OPAMP);
      end
    end else begin
      // scanning only walks external inputs
      case (scan_count_select)
        `CNT_4: begin
          last_slot = 2'd3;
          prohibited_nxt = internal_source_select || (code > `MAX_SCAN4);
        end
        `CNT_3: begin
          last_slot = 2'd2;
          prohibited_nxt = internal_source_select || (code > `MAX_SCAN3);
        end
        `CNT_2: begin
          last_slot = 2'd1;
          prohibited_nxt = internal_source_select || (code > `MAX_SCAN2);
        end
        default: begin
          last_slot = 2'd0;
          prohibited_nxt = 1'b1;
        end
      endcase
    end
  end

  // channel currently being converted: start code plus slot in scan mode
  wire [5:0] cur_channel = channel_selection_mode ? (code + {4'h0, slot_r}) : code;

  // scan slot sequencing, ascending and wrapping while running
  reg [1:0] slot_nxt;
  always @* begin
    slot_nxt = slot_r;
    if (!channel_selection_mode || !conversion_start_bit) begin
      slot_nxt = 2'd0;
    end else if (conv_done) begin
      if (slot_r >= last_slot) begin
        slot_nxt = 2'd0;
      end else begin
        slot_nxt = slot_r + 2'd1;
      end
    end
  end

  // upper nibble: zero in select mode, channel id when tagging in scan mode
  wire [3:0] tag_nxt = (channel_selection_mode && channel_tag_enable) ?
                       cur_channel[3:0] : 4'h0;

  // apb decode; the slave answers in the access cycle after one wait state
  wire apb_access = psel && penable && !access_r;
  wire is_chsel = (paddr == `OFF_CHSEL);
  wire is_result = (paddr == `OFF_RESULT);
  wire is_rbyte = (paddr == `OFF_RESULT_BYTE);
  wire is_ctrl = (paddr == `OFF_CTRL);
  wire is_status = (paddr == `OFF_STATUS);
  wire mapped = is_chsel || is_result || is_rbyte || is_ctrl || is_status;

  reg [31:0] rdata_nxt;
  always @* begin
    rdata_nxt = 32'h0000_0000;
    if (is_chsel) begin
      rdata_nxt = {24'h00_0000, chsel_r};
    end else if (is_result) begin
      rdata_nxt = {16'h0000, result_r};
    end else if (is_rbyte) begin
      rdata_nxt = {24'h00_0000, result_byte_r};
    end else if (is_ctrl) begin
      rdata_nxt = {25'h000_0000, ctrl_r};
    end else if (is_status) begin
      rdata_nxt = {23'h00_0000, setting_prohibited, slot_r, cur_channel};
    end
  end

  // bus slave and control registers
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      chsel_r <= `CHSEL_RESET;
      ctrl_r <= `CTRL_RESET;
      access_r <= 1'b0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      access_r <= apb_access;
      pready <= apb_access;
      pslverr <= apb_access && !mapped;
      prdata <= (apb_access && !pwrite) ? rdata_nxt : 32'h0000_0000;
      if (apb_access && pwrite) begin
        // channel select bit 6 is held at zero; result registers are read-only
        if (is_chsel) begin
          chsel_r <= pwdata[7:0] & `CHSEL_WMASK;
        end else if (is_ctrl) begin
          ctrl_r <= pwdata[6:0] & `CTRL_WMASK;
        end
      end else if (conv_done && single_conv && conversion_start_bit &&
                   (!channel_selection_mode || slot_r >= last_slot)) begin
        // single mode stops after one pass
        ctrl_r[`CTRL_START_BIT] <= 1'b0;
      end
    end
  end

  // result capture; software keeps the internal-source bit steady while running
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      result_r <= `RESULT_RESET;
      result_byte_r <= `RESULT_BYTE_RESET;
      slot_r <= 2'd0;
      scan_slot <= 2'd0;
      mux_channel <= 6'h00;
      mux_internal <= 1'b0;
      setting_prohibited <= 1'b0;
    end else begin
      slot_r <= slot_nxt;
      scan_slot <= slot_nxt;
      mux_channel <= channel_selection_mode ?
                     (code + {4'h0, slot_nxt}) : code;
      mux_internal <= internal_source_select && !channel_selection_mode;
      setting_prohibited <= prohibited_nxt;
      // out-of-range results are dropped so the previous value stays
      if (conv_done && in_range) begin
        result_r <= {tag_nxt, sar_value};
        result_byte_r <= sar_value[11:4];
      end
    end
  end

  // unused comparator bit kept for control register readback only
  wire unused_ok = comparator_enable_bit;

endmodule

// ### shared/adc_chsel_regs.vh
// register map, field positions and reset values for the channel select / result block
// assumes a 32-bit apb slave, one aligned word per register
`ifndef ADC_CHSEL_REGS_VH
`define ADC_CHSEL_REGS_VH
// byte offsets
`define OFF_CHSEL 12'h000
`define OFF_RESULT 12'h004
`define OFF_RESULT_BYTE 12'h008
`define OFF_CTRL 12'h00C
`define OFF_STATUS 12'h010
// channel select fields
`define CHSEL_ISS_BIT 7
`define CHSEL_RESET 8'h00
`define CHSEL_WMASK 8'hBF
// control register fields
`define CTRL_MODE_BIT 0
`define CTRL_CNT_LO 1
`define CTRL_CNT_HI 2
`define CTRL_TAG_BIT 3
`define CTRL_SINGLE_BIT 4
`define CTRL_START_BIT 5
`define CTRL_CMPEN_BIT 6
`define CTRL_RESET 7'h00
`define CTRL_WMASK 7'h7F
// scan counts
`define CNT_4 2'b00
`define CNT_3 2'b01
`define CNT_2 2'b10
// last legal start codes, plus the lone legal opamp and internal codes
`define MAX_SEL_EXT 6'h19
`define CODE_OPAMP 6'h23
`define CODE_TEMP 6'h00
`define CODE_BGR 6'h01
`define MAX_SCAN4 6'h0C
`define MAX_SCAN3 6'h0D
`define MAX_SCAN2 6'h0E
// result
`define RESULT_RESET 16'h0000
`define RESULT_BYTE_RESET 8'h00
`endif

// ### testbench/adc_chsel_sva.sv
// port assertions for the channel select and result block
// assumes a bind from the bench top file
`timescale 1ns/10ps
module adc_chsel_sva (
  input wire clk, // clock
  input wire resetn, // reset
  input wire psel, // apb
  input wire penable, // apb
  input wire pready, // apb
  input wire pslverr, // apb
  input wire conv_done, // done
  input wire [5:0] mux_channel, // mux
  input wire mux_internal, // mux
  input wire [1:0] scan_slot, // slot
  input wire setting_prohibited // bad
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // apb answers one cycle after the access edge
  sequence acc_s;
    psel && penable && !pready;
  endsequence
  AST_WAIT: assert property (acc_s |=> pready) else $error("no ready");
  AST_ERR: assert property (pslverr |-> pready) else $error("stray error");
  AST_RST: assert property ($rose(resetn) |-> scan_slot == 2'd0) else $error("reset");
  // slot moves only on a finished conversion or a bus access; a done steps it up by one or back to 0
  AST_STEP: assert property (conv_done |=>
    scan_slot == 2'd0 || scan_slot == $past(scan_slot) + 2'd1) else $error("step");
  AST_HOLD: assert property (!conv_done && !psel |=> $stable(scan_slot))
    else $error("slot moved");
  AST_NEXT: assert property ($changed(scan_slot) && scan_slot != 2'd0 |->
    mux_channel == $past(mux_channel) + 6'd1) else $error("mux step");
  AST_SEL: assert property (!mux_internal && !setting_prohibited |->
    mux_channel <= 6'h19 || mux_channel == 6'h23) else $error("mux code");
  AST_TOP: assert property (scan_slot == 2'd3 && !setting_prohibited |->
    mux_channel >= 6'h03 && mux_channel <= 6'h0F) else $error("scan range");
endmodule

// ### testbench/sar_core_model.sv
// stand-in for the converter core: one done pulse per request
// assumes the bench raises go for one cycle with value and verdict
`timescale 1ns/10ps
module sar_core_model (
  input wire clk, // clock
  input wire go, // request
  input wire [11:0] val, // value
  input wire rng, // verdict
  output reg conv_done = 1'b0, // done pulse
  output reg [11:0] sar_value = 12'h0000, // value
  output reg in_range = 1'b0 // verdict
);
  // idle outputs are scrambled so nothing leans on stale data
  always @(posedge clk) begin
    conv_done <= go;
    sar_value <= go ? val : ~val;
    in_range <= go ? rng : ~rng;
  end
endmodule

// ### testbench/adc_channel_select_result_tb_top.sv
// self-checking bench for the channel select and result block
// assumes the register header on the include path
`timescale 1ns/10ps
module adc_channel_select_result_tb_top;
  reg clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, go = 0, rng = 0, err;
  reg [11:0] paddr = 0, val = 0;
  reg [31:0] pwdata = 0, rd;
  reg [44:0] rows [0:3]; // chsel, ctrl, value, verdict, word
  wire [31:0] prdata;
  wire pready, pslverr, conv_done, in_range, mux_internal, setting_prohibited;
  wire [11:0] sar_value;
  wire [5:0] mux_channel;
  wire [1:0] scan_slot;
  integer fails = 0, cmp_count = 0, i, m, k;
  initial forever #5 clk = ~clk;
  adc_channel_select_result dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .conv_done(conv_done), .sar_value(sar_value), .in_range(in_range),
    .mux_channel(mux_channel), .mux_internal(mux_internal), .scan_slot(scan_slot),
    .setting_prohibited(setting_prohibited));
  sar_core_model core (.clk(clk), .go(go), .val(val), .rng(rng), .conv_done(conv_done),
    .sar_value(sar_value), .in_range(in_range));
  task chk(input [63:0] nm, input [31:0] seen, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("FAIL %s exp %h seen %h", nm, exp, seen);
      end
    end
  endtask
  // one apb transfer; request held until ready is sampled
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      k = 0;
      @(posedge clk);
      while (pready !== 1'b1 && k < 20) begin
        @(posedge clk);
        k = k + 1;
      end
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge clk);
    end
  endtask
  task conv(input [11:0] v, input r);
    begin
      go <= 1;
      val <= v;
      rng <= r;
      @(posedge clk);
      go <= 0;
      repeat (2) @(posedge clk);
    end
  endtask
  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  // internal bit only changes while control is stopped
  initial begin
    rows[0] = {8'h05, 8'h00, 12'hABC, 1'b1, 16'h0ABC};
    rows[1] = {8'h19, 8'h08, 12'h123, 1'b1, 16'h0123};
    rows[2] = {8'h23, 8'h00, 12'hFFF, 1'b0, 16'h0123};
    rows[3] = {8'h81, 8'h00, 12'h5A5, 1'b1, 16'h05A5};
    repeat (3) @(posedge clk);
    resetn <= 1;
    @(posedge clk);
    apb(0, 12'h000, 0);
    chk("sel", rd, 0);
    chk("noerr", err, 0);
    apb(0, 12'h004, 0);
    chk("word", rd, 0);
    // stimulus keeps inputs 8/9 off external refs, no sleep entry, pins analog
    // temp sensor only picked with no 1.45V comparator ref; internal row result is kept
    for (i = 0; i < 4; i = i + 1) begin
      apb(1, 12'h000, rows[i][44:37]);
      apb(1, 12'h00C, rows[i][36:29]);
      chk("mux", mux_channel, rows[i][42:37]);
      chk("int", mux_internal, rows[i][44]);
      conv(rows[i][28:17], rows[i][16]);
      apb(0, 12'h004, 0);
      chk("word", rd, rows[i][15:0]);
      apb(0, 12'h008, 0);
      chk("byte", rd, rows[i][11:4]);
    end
    apb(1, 12'h000, 32'hC0);
    apb(0, 12'h000, 0);
    chk("sel", rd, 32'h80);
    for (m = 0; m < 3; m = m + 1) begin
      apb(1, 12'h00C, 0);
      apb(1, 12'h000, 12 + m);
      apb(1, 12'h00C, 32'h29 | (m << 1));
      for (i = 0; i < 5 - m; i = i + 1) begin
        conv(12'h321, 1);
        apb(0, 12'h004, 0);
        chk("tag", rd, ((12 + m + i % (4 - m)) << 12) | 32'h321);
        chk("slot", scan_slot, (i + 1) % (4 - m));
      end
    end
    apb(1, 12'h00C, 0);
    apb(1, 12'h000, 13);
    apb(1, 12'h00C, 32'h21);
    apb(0, 12'h010, 0);
    chk("bad4", rd[8], 1);
    apb(1, 12'h00C, 32'h07);
    apb(0, 12'h010, 0);
    chk("bad11", rd[8], 1);
    apb(1, 12'h004, 32'hFFFF);
    apb(0, 12'h004, 0);
    chk("ro", rd, 32'hE321);
    apb(0, 12'h020, 0);
    chk("err", err, 1);
    // reset with control stopped must bring slot, result word and channel select back
    resetn <= 0;
    @(posedge clk);
    resetn <= 1;
    @(posedge clk);
    chk("slot0", scan_slot, 0);
    apb(0, 12'h004, 0);
    chk("word0", rd, 0);
    apb(0, 12'h000, 0);
    chk("sel0", rd, 0);
    wrap_up;
  end
  initial begin
    #200000;
    fails = fails + 1;
    wrap_up;
  end
endmodule
bind adc_channel_select_result adc_chsel_sva chk_i (.clk(clk), .resetn(resetn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .conv_done(conv_done),
  .mux_channel(mux_channel), .mux_internal(mux_internal), .scan_slot(scan_slot),
  .setting_prohibited(setting_prohibited));
